// File: core/xpt_ctrl_pkg.sv
package xpt_ctrl_pkg;

  // Register byte offsets of the controller's own APB register file.
  localparam logic [7:0] ctrl_off   = 8'h00;  // Command register.
  localparam logic [7:0] route_off  = 8'h04;  // Route setting for a load command.
  localparam logic [7:0] sel_off    = 8'h08;  // Device row and column selection.
  localparam logic [7:0] status_off = 8'h0C;  // Busy and completion status.
  localparam logic [7:0] shadow_off = 8'h10;  // Last committed route word per output, from the last command to any row.

  // Command field positions in the command register.
  localparam int cmd_load_bit   = 0;  // Load one first-rank setting.
  localparam int cmd_commit_bit = 1;  // Commit all first-rank settings.
  localparam int cmd_clear_bit  = 2;  // Clear pulse, all outputs to input 0.

  // Route register fields.
  localparam int route_out_lsb = 0;  // Output index, 3 bits.
  localparam int route_in_lsb  = 4;  // Input index, 3 bits.
  localparam int route_flt_bit = 8;  // Float control for load or clear.

  // Selection register fields.
  localparam int sel_row_lsb = 0;  // Row selector, 3 bits.
  localparam int sel_col_lsb = 8;  // Column selector, 3 bits.
  localparam int sel_bcast_bit = 16;  // Drive all float lines with the route float bit together.

  // Reset values.
  localparam logic [31:0] route_rst = 32'h0000_0000;
  localparam logic [31:0] sel_rst   = 32'h0000_0000;

  // Strobe timing in nanoseconds, rounded up to whole clock cycles.
  localparam int clk_ns     = 100;
  localparam int setup_ns   = 200;  // Buses stable before a strobe rises.
  localparam int pulse_ns   = 200;  // Strobe high time.
  localparam int hold_ns    = 200;  // Buses kept after a strobe falls.
  localparam int setup_cyc  = (setup_ns + clk_ns - 1) / clk_ns;
  localparam int pulse_cyc  = (pulse_ns + clk_ns - 1) / clk_ns;
  localparam int hold_cyc   = (hold_ns + clk_ns - 1) / clk_ns;

  // Sequencer states.
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_setup = 2'b01,
    st_pulse = 2'b10,
    st_hold  = 2'b11
  } seq_state_t;

  // Strobe kinds.
  typedef enum logic [1:0] {
    kind_load   = 2'b00,
    kind_commit = 2'b01,
    kind_clear  = 2'b10
  } strobe_kind_t;

endpackage : xpt_ctrl_pkg

// File: core/xpt_ctrl.sv
// Design decisions made here: the placing of the registers and register access over APB.
module xpt_ctrl #(
  parameter int rows = 8,  // Device rows, one chip select each.
  parameter int cols = 8   // Device columns, one float line each.
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic      [2:0]      output_select_bus,
  output logic      [2:0]      input_select_bus,
  output logic      [cols-1:0] float_ctrl,
  output logic      [rows-1:0] chip_sel,
  output logic                 load_strobe,
  output logic                 commit_strobe,
  output logic                 clear_pulse
);

  // The row and column selectors are 3-bit fields, so wider arrays cannot be addressed.
  // The check sits at elaboration, so a bad build stops before any cycle runs.
  if (rows < 1 || rows > 8 || cols < 1 || cols > 8) begin : g_bad_size
    $error("xpt_ctrl: rows and cols must lie in 1 to 8.");
  end

  // Software-visible state.
  logic [31:0] route_reg, route_next;   // Output, input and float for the next command.
  logic [31:0] sel_reg, sel_next;       // Row and column selection.
  logic [7:0]  done_reg, done_next;     // Count of completed commands, wraps.
  logic        err_reg, err_next;       // Sticky: a command was refused while busy.
  // Pin and sequencer state.
  xpt_ctrl_pkg::seq_state_t   state_reg, state_next;
  xpt_ctrl_pkg::strobe_kind_t kind_reg, kind_next;
  logic [3:0]      cnt_reg, cnt_next;   // Cycles left in the current phase.
  logic [2:0]      osel_reg, osel_next;
  logic [2:0]      isel_reg, isel_next;
  logic [cols-1:0] flt_reg, flt_next;
  logic [rows-1:0] cs_reg, cs_next;
  logic            load_reg, load_next;
  logic            commit_reg, commit_next;
  logic            clear_reg, clear_next;
  // Host-side mirror of the device settings, updated by every command whatever row and column it addresses.
  logic [3:0] first_reg [8];
  logic [3:0] first_next [8];
  logic [3:0] second_reg [8];
  logic [3:0] second_next [8];
  // APB answer.
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;

  logic        access;      // Second cycle of an APB transfer.
  logic        wr_cmd;      // Write to the command register.
  logic [2:0]  row_idx, col_idx;
  logic [rows-1:0] row_onehot;
  logic [cols-1:0] col_onehot;
  logic        cmd_flt;

  // Decoded views of the software registers. The float bit is read live, so software
  // must leave the route register alone while a command is busy, or the mirror drifts.
  assign access  = psel && penable && !pready;
  assign wr_cmd  = access && pwrite && (paddr == xpt_ctrl_pkg::ctrl_off);
  assign row_idx = sel_reg[xpt_ctrl_pkg::sel_row_lsb +: 3];
  assign col_idx = sel_reg[xpt_ctrl_pkg::sel_col_lsb +: 3];
  assign cmd_flt = route_reg[xpt_ctrl_pkg::route_flt_bit];

  // One-hot row decoder, one chip select per row; inverted column decoder, one float line per column.
  // A broadcast overrides the column decoder in the sequencer further down.
  genvar g;
  generate
    for (g = 0; g < rows; g++) begin : g_row
      assign row_onehot[g] = (row_idx == 3'(g));
    end
    for (g = 0; g < cols; g++) begin : g_col
      // Inverted decoder outputs: only the selected column may drive.
      assign col_onehot[g] = (col_idx != 3'(g));
    end
  endgenerate

  // APB slave: one wait state, so the answer comes in the second access cycle.
  always_comb begin
    route_next   = route_reg;
    sel_next     = sel_reg;
    err_next     = err_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    // A transfer is taken in its first access cycle and answered in the next.
    if (access) begin
      pready_next = 1'b1;
      if (pwrite) begin
        case (paddr)
          xpt_ctrl_pkg::ctrl_off: begin
            // A command while busy is refused and flagged.
            // The refused command leaves the pins and the mirror untouched.
            if (state_reg != xpt_ctrl_pkg::st_idle) begin
              err_next = 1'b1;
            end
          end
          xpt_ctrl_pkg::route_off:  route_next = pwdata & 32'h0000_0177;
          xpt_ctrl_pkg::sel_off:    sel_next = pwdata & 32'h0001_0707;
          xpt_ctrl_pkg::status_off: begin
            // Writing bit 1 clears the sticky refusal flag.
            if (pwdata[1]) begin
              err_next = 1'b0;
            end
          end
          default: pslverr_next = 1'b1;
        endcase
      end else begin
        case (paddr)
          xpt_ctrl_pkg::ctrl_off:   prdata_next = 32'h0000_0000;
          xpt_ctrl_pkg::route_off:  prdata_next = route_reg;
          xpt_ctrl_pkg::sel_off:    prdata_next = sel_reg;
          xpt_ctrl_pkg::status_off: begin
            prdata_next = {16'h0000, done_reg, 6'h00, err_reg, state_reg != xpt_ctrl_pkg::st_idle};
          end
          xpt_ctrl_pkg::shadow_off: begin
            for (int i = 0; i < 8; i++) begin
              prdata_next[4*i +: 4] = second_reg[i];
            end
          end
          default: pslverr_next = 1'b1;
        endcase
      end
    end
  end

  // Strobe sequencer: buses settle, strobe rises, strobe falls, buses held.
  // Each phase lasts its own count of cycles, so setup and hold around the
  // strobe edge are met for the clock rate the counts were reckoned for.
  always_comb begin
    state_next  = state_reg;
    kind_next   = kind_reg;
    cnt_next    = cnt_reg;
    osel_next   = osel_reg;
    isel_next   = isel_reg;
    flt_next    = flt_reg;
    cs_next     = cs_reg;
    load_next   = load_reg;
    commit_next = commit_reg;
    clear_next  = clear_reg;
    done_next   = done_reg;
    for (int i = 0; i < 8; i++) begin
      first_next[i]  = first_reg[i];
      second_next[i] = second_reg[i];
    end
    case (state_reg)
      xpt_ctrl_pkg::st_idle: begin
        // No strobe runs, so no device is selected and none can act.
        cs_next = '0;
        if (wr_cmd) begin
          // Priority clear over commit over load; only one strobe ever rises.
          if (pwdata[xpt_ctrl_pkg::cmd_clear_bit]) begin
            kind_next = xpt_ctrl_pkg::kind_clear;
          end else if (pwdata[xpt_ctrl_pkg::cmd_commit_bit]) begin
            kind_next = xpt_ctrl_pkg::kind_commit;
          end else begin
            kind_next = xpt_ctrl_pkg::kind_load;
          end
          if (pwdata[2:0] != 3'h0) begin
            state_next = xpt_ctrl_pkg::st_setup;
            cnt_next   = 4'(xpt_ctrl_pkg::setup_cyc);
            osel_next  = route_reg[xpt_ctrl_pkg::route_out_lsb +: 3];
            isel_next  = route_reg[xpt_ctrl_pkg::route_in_lsb +: 3];
            cs_next    = row_onehot;
            if (sel_reg[xpt_ctrl_pkg::sel_bcast_bit]) begin
              flt_next = {cols{cmd_flt}};
            end else begin
              // Unselected columns float whatever the command asks.
              flt_next = col_onehot | {cols{cmd_flt}};
            end
          end
        end
      end
      xpt_ctrl_pkg::st_setup: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          state_next = xpt_ctrl_pkg::st_pulse;
          cnt_next   = 4'(xpt_ctrl_pkg::pulse_cyc);
          // The strobe kind was fixed when the command was taken.
          case (kind_reg)
            xpt_ctrl_pkg::kind_clear:  clear_next = 1'b1;
            xpt_ctrl_pkg::kind_commit: commit_next = 1'b1;
            default:                   load_next = 1'b1;
          endcase
        end
      end
      xpt_ctrl_pkg::st_pulse: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          state_next  = xpt_ctrl_pkg::st_hold;
          cnt_next    = 4'(xpt_ctrl_pkg::hold_cyc);
          // Every strobe falls together; only one of them was raised.
          load_next   = 1'b0;
          commit_next = 1'b0;
          clear_next  = 1'b0;
          // Track what the device now holds; setting is {input, enable}.
          case (kind_reg)
            xpt_ctrl_pkg::kind_clear: begin
              for (int i = 0; i < 8; i++) begin
                first_next[i]  = {3'h0, ~cmd_flt};
                second_next[i] = {3'h0, ~cmd_flt};
              end
            end
            xpt_ctrl_pkg::kind_commit: begin
              // All eight copy at once; equal words leave routing untouched.
              for (int i = 0; i < 8; i++) begin
                second_next[i] = first_reg[i];
              end
            end
            default: first_next[osel_reg] = {isel_reg, ~cmd_flt};
          endcase
        end
      end
      xpt_ctrl_pkg::st_hold: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          state_next = xpt_ctrl_pkg::st_idle;
          cs_next    = '0;
          // Chip select drops only after the hold time, so the buses stay valid for the device.
          done_next  = done_reg + 8'h01;
        end
      end
      default: state_next = xpt_ctrl_pkg::st_idle;
    endcase
  end

  // Registers; every output comes straight from one of these.
  // Float lines reset high so that no device drives a shared line before setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg  <= xpt_ctrl_pkg::route_rst;
      sel_reg    <= xpt_ctrl_pkg::sel_rst;
      err_reg    <= 1'b0;
      done_reg   <= 8'h00;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      state_reg  <= xpt_ctrl_pkg::st_idle;
      kind_reg   <= xpt_ctrl_pkg::kind_load;
      cnt_reg    <= 4'h0;
      osel_reg   <= 3'h0;
      isel_reg   <= 3'h0;
      flt_reg    <= '1;  // Float all lines until software programs them.
      cs_reg     <= '0;
      load_reg   <= 1'b0;
      commit_reg <= 1'b0;
      clear_reg  <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        first_reg[i]  <= 4'h0;
        second_reg[i] <= 4'h0;
      end
    end else begin
      route_reg  <= route_next;
      sel_reg    <= sel_next;
      err_reg    <= err_next;
      done_reg   <= done_next;
      prdata     <= prdata_next;
      pready     <= pready_next;
      pslverr    <= pslverr_next;
      state_reg  <= state_next;
      kind_reg   <= kind_next;
      cnt_reg    <= cnt_next;
      osel_reg   <= osel_next;
      isel_reg   <= isel_next;
      flt_reg    <= flt_next;
      cs_reg     <= cs_next;
      load_reg   <= load_next;
      commit_reg <= commit_next;
      clear_reg  <= clear_next;
      for (int i = 0; i < 8; i++) begin
        first_reg[i]  <= first_next[i];
        second_reg[i] <= second_next[i];
      end
    end
  end

  // Pin outputs; each is a register, so the strobes carry no glitches.
  // The far devices act on strobe edges, so a glitch would be a false command.
  assign output_select_bus = osel_reg;
  assign input_select_bus  = isel_reg;
  assign float_ctrl        = flt_reg;
  assign chip_sel          = cs_reg;
  assign load_strobe       = load_reg;
  assign commit_strobe     = commit_reg;
  assign clear_pulse       = clear_reg;

endmodule : xpt_ctrl

// File: tb/xpt_dev_model.sv
// Behavioural crosspoint device; no clock, it acts on strobe edges only.
module xpt_dev_model (
  input  wire logic        cs,
  input  wire logic        flt,
  input  wire logic [2:0]  osel,
  input  wire logic [2:0]  isel,
  input  wire logic        load,
  input  wire logic        commit,
  input  wire logic        clear,
  output logic      [31:0] cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rank1;  // First rank, one nibble per output.
  initial begin
    rank1 = 32'h0;
    cfg = 32'h0;
  end
  // Clear routes everything to input 0; enable is the inverse of float.
  always @(posedge clear) if (cs) begin
    rank1 = {8{3'h0, ~flt}};
    cfg = rank1;
  end
  // A load writes only the first rank, so active routing stays put.
  always @(posedge load) if (cs && !clear && !commit) rank1[osel*4+:4] = {isel, ~flt};
  // Commit copies all eight settings at once.
  always @(posedge commit) if (cs) cfg = rank1;
endmodule : xpt_dev_model

// File: tb/xpt_ctrl_properties.sv
// Pin sequencing checks for the controller side.
module xpt_ctrl_properties #(
  parameter int rows = 8,
  parameter int cols = 8
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic [2:0]      output_select_bus,
  input wire logic [2:0]      input_select_bus,
  input wire logic [rows-1:0] chip_sel,
  input wire logic            load_strobe,
  input wire logic            commit_strobe,
  input wire logic            clear_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_load_width: assert property ($rose(load_strobe) |-> ##1 load_strobe ##1 !load_strobe[*2])
    else $error("load strobe width wrong");
  a_commit_width: assert property ($rose(commit_strobe) |-> ##1 commit_strobe ##1 !commit_strobe)
    else $error("commit strobe width wrong");
  a_clear_width: assert property ($rose(clear_pulse) |-> ##1 clear_pulse ##1 !clear_pulse)
    else $error("clear pulse width wrong");
  a_cs_onehot: assert property ((load_strobe | commit_strobe | clear_pulse) |-> $onehot(chip_sel))
    else $error("chip select not one-hot");
  a_cs_setup: assert property ($rose(load_strobe) |-> $past(chip_sel, 2) == chip_sel)
    else $error("chip select not set up");
  a_bus_hold: assert property (load_strobe |-> $stable(output_select_bus) && $stable(input_select_bus))
    else $error("buses moved under strobe");
  a_one_strobe: assert property (!(load_strobe && commit_strobe) && !(load_strobe && clear_pulse) && !(commit_strobe && clear_pulse))
    else $error("two strobes at once");
  a_cs_release: assert property ($fell(load_strobe) |-> $stable(chip_sel) ##2 chip_sel == '0)
    else $error("chip select not released");
  c_load: cover property ($rose(load_strobe));
  c_commit: cover property ($rose(commit_strobe));
  c_clear: cover property ($rose(clear_pulse));
endmodule : xpt_ctrl_properties
bind xpt_ctrl xpt_ctrl_properties #(.rows(rows), .cols(cols)) u_props (.pclk(pclk), .presetn(presetn),
  .output_select_bus(output_select_bus), .input_select_bus(input_select_bus), .chip_sel(chip_sel),
  .load_strobe(load_strobe), .commit_strobe(commit_strobe), .clear_pulse(clear_pulse));

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, cfg, shadow;
  logic pready, pslverr, load_strobe, commit_strobe, clear_pulse;
  logic [2:0] output_select_bus, input_select_bus;
  logic [7:0] float_ctrl, chip_sel;
  logic [32:0] exp_q[$], msk_q[$];  // Expected {error, data} and compare mask.
  int num_errors = 0, tests_run = 0, ncmd = 0, cycles = 0;
  logic [2:0] in_idx;
  logic fl;
  always #50 pclk = ~pclk;
  xpt_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_select_bus(output_select_bus),
    .input_select_bus(input_select_bus), .float_ctrl(float_ctrl), .chip_sel(chip_sel),
    .load_strobe(load_strobe), .commit_strobe(commit_strobe), .clear_pulse(clear_pulse));
  // Device zero sits on row 0, column 0; rows elsewhere must not reach it.
  xpt_dev_model dev0 (.cs(chip_sel[0]), .flt(float_ctrl[0]), .osel(output_select_bus), .isel(input_select_bus),
    .load(load_strobe), .commit(commit_strobe), .clear(clear_pulse), .cfg(cfg));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // Read answers are matched against the oldest note in the queue.
  always @(posedge pclk) if (pready && psel && !pwrite) begin
    chk({pslverr, prdata} & msk_q[0], exp_q[0]);
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // A command runs to completion in six cycles, so eight are waited.
  task automatic cmd(input logic [31:0] route, input int b);
    apb(1'b1, 8'h04, route);
    apb(1'b1, 8'h00, 32'h1 << b);
    repeat (8) @(posedge pclk);
    ncmd++;
  endtask : cmd
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    logic [31:0] expv;
    void'($urandom(32'hF5B607B3));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 33'h0, 33'h1FFFFFFFF);
    rd(8'h08, 33'h0, 33'h1FFFFFFFF);
    rd(8'h40, 33'h100000000, 33'h100000000);
    chk({14'h0, load_strobe, commit_strobe, clear_pulse, chip_sel, float_ctrl}, 33'hFF);
    $display("test reset_and_map done");
    expv = 32'h0;
    for (int i = 0; i < 8; i++) begin
      in_idx = 3'($urandom);
      fl = 1'($urandom);
      cmd({23'h0, fl, 1'b0, in_idx, 1'b0, 3'(i)}, 0);
      expv[i*4+:4] = {in_idx, ~fl};
    end
    chk({1'b0, cfg}, 33'h0);
    cmd(32'h0, 1);
    chk({1'b0, cfg}, {1'b0, expv});
    rd(8'h10, {1'b0, expv}, 33'h1FFFFFFFF);
    $display("test load_commit done");
    apb(1'b1, 8'h08, 32'h1);
    cmd(32'h176, 0);
    cmd(32'h0, 2);
    cmd(32'h0, 1);
    chk({1'b0, cfg}, {1'b0, expv});
    apb(1'b1, 8'h08, 32'h0);
    $display("test other_row done");
    for (int f = 0; f < 2; f++) begin
      cmd(32'(f) << 8, 2);
      chk({1'b0, cfg}, f ? 33'h0 : 33'h11111111);
    end
    $display("test clear done");
    apb(1'b1, 8'h08, 32'h100);
    cmd(32'h10, 0);
    chk({25'h0, float_ctrl}, 33'hFD);
    cmd(32'h0, 1);
    chk({1'b0, cfg}, 33'h2);
    apb(1'b1, 8'h08, 32'h10100);
    cmd(32'h10, 0);
    chk({25'h0, float_ctrl}, 33'h0);
    cmd(32'h0, 1);
    chk({1'b0, cfg}, 33'h3);
    apb(1'b1, 8'h08, 32'h0);
    $display("test columns done");
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    rd(8'h0C, 33'h2, 33'h2);
    repeat (8) @(posedge pclk);
    ncmd++;
    rd(8'h0C, 33'(ncmd) << 8 | 33'h2, 33'hFF03);
    apb(1'b1, 8'h0C, 32'h2);
    rd(8'h0C, 33'h0, 33'h2);
    $display("test refuse_and_count done");
    complete_run();
  end
endmodule : testbench
